// [shared/ppl_pkg.sv]
// Constants, register map and carrier types for the ping-pong line transceiver.
// Function
// - Start one transmit burst every 250 us.
// - Stop listening more than guard before next burst.
// - Send 38-bit frames at 384 kbit/s.
// - Frame carries 4 D, 16 B1, 16 B2 bits.
// - Leading frame bit is always one.
// - Last bit is M; four M-bits form superframe.
// - First M position carries violation for superframe sync.
// - Third M-bit is service bit, host visible.
// - Second and fourth M-bits carry T-bit.
// - Append balance bit after M-bit violation when allowed.
// - Half-bauded AMI, ones alternate pulse polarity.
// - Violation is two same-polarity pulses in a row.
// - Timing comparator switches at 80 percent of peak.
// - Loop corrects after four same-sign phase errors.
// - Correction step 65 or 32.5 ns, reset 65.
// - Six samples per bit at 15.36 MHz spacing.
// - One when at least n samples exceed half peak.
// - Direction output shows transmit or receive.
package ppl_pkg;

  // The system clock feeds a fractional divider that yields half-ticks of 30.72 MHz.
  localparam int CLK_HZ = 250_000_000;
  localparam int HT_HZ = 30_720_000;
  localparam logic [14:0] NCO_MOD = 15'(CLK_HZ / 10_000);
  localparam logic [14:0] NCO_INC = 15'(HT_HZ / 10_000);

  localparam int PERIOD_US = 250;
  localparam logic [12:0] PERIOD_HT = 13'(PERIOD_US * (HT_HZ / 1_000_000) + PERIOD_US * 72 / 100);
  localparam int BIT_RATE = 384_000;
  localparam logic [6:0] BIT_HT = 7'(HT_HZ / BIT_RATE);
  localparam logic [6:0] PULSE_HT = 7'(HT_HZ / BIT_RATE / 2);
  localparam logic [5:0] FRAME_BITS = 6'd38;
  localparam int GUARD_NS = 5200;
  localparam logic [12:0] GUARD_HT = 13'((GUARD_NS * 3072 + 99_999) / 100_000);
  localparam int STEP_LONG_NS = 65;
  localparam int STEP_SHORT_PS = 32_500;
  localparam logic [1:0] STEP_LONG_HT = 2'((STEP_LONG_NS * 3072 + 50_000) / 100_000);
  localparam logic [1:0] STEP_SHORT_HT = 2'((STEP_SHORT_PS / 100 * 3072 + 500_000) / 1_000_000);
  localparam logic [2:0] TRACK_COUNT = 3'd4;
  localparam logic [6:0] SAMPLE_FIRST = 7'd12;
  localparam logic [6:0] SAMPLE_LAST = 7'd22;

  // Register byte offsets.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_TXB = 5'h04;
  localparam logic [4:0] REG_TXD = 5'h08;
  localparam logic [4:0] REG_RXB = 5'h0c;
  localparam logic [4:0] REG_STAT = 5'h10;

  localparam logic [11:0] CTRL_RESET = 12'h0;

  // Control register fields, high bits first in the register word.
  typedef struct packed {
    logic degraded;
    logic activated;
    logic txT;
    logic txService;
    logic [1:0] ampControl;
    logic eqFilter;
    logic pllIntegral;
    logic pllStepShort;
    logic balanceEn;
    logic lineEnable;
    logic spare;
  } ppl_ctrl_t;

  typedef struct packed {
    logic [15:0] b2;
    logic [15:0] b1;
  } ppl_bdata_t;

  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_LISTEN, ST_RECV} ppl_state_t;

endpackage : ppl_pkg

// [logic/ppl_line_transceiver.sv]
// Exchange-side ping-pong line transceiver with AMI coding and oversampling receiver.
`timescale 1ns/1ns
module ppl_line_transceiver (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Avalon-MM register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Line comparators
  input wire logic rxPeak80,
  input wire logic rxPos50,
  input wire logic rxNeg50,
  // Line drivers and direction
  output logic txPos,
  output logic txNeg,
  output logic lineDirTx,
  // Equalizer settings toward the analog front end
  output logic eqFilterEnable,
  output logic [1:0] ampControlSelect
);
  import ppl_pkg::*;

  // Half-tick generator.
  logic [14:0] ncoAcc_r;
  logic ht_r;
  wire logic [15:0] ncoSum = {1'b0, ncoAcc_r} + {1'b0, NCO_INC};
  wire logic ncoWrap = ncoSum >= {1'b0, NCO_MOD};
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ncoAcc_r <= 15'h0;
      ht_r <= 1'b0;
    end else begin
      ncoAcc_r <= ncoWrap ? 15'(ncoSum - {1'b0, NCO_MOD}) : ncoSum[14:0];
      ht_r <= ncoWrap;
    end
  end

  // Three-stage input synchronisers; a level counts once stages two and three agree.
  logic [2:0] s1_r, s2_r, s3_r, rxLvl_r, rxLvlOld_r;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      s3_r <= 3'h0;
      rxLvl_r <= 3'h0;
      rxLvlOld_r <= 3'h0;
    end else begin
      s1_r <= {rxNeg50, rxPos50, rxPeak80};
      s2_r <= s1_r;
      s3_r <= s2_r;
      rxLvl_r <= (s3_r & (s2_r ~^ s3_r)) | (rxLvl_r & (s2_r ^ s3_r));
      rxLvlOld_r <= rxLvl_r;
    end
  end

  // A comparator edge lasts one clock but is consumed on a half-tick, so it is held until the next one.
  logic peakHold_r;
  wire logic peakRise = rxLvl_r[0] & ~rxLvlOld_r[0];
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      peakHold_r <= 1'b0;
    end else begin
      peakHold_r <= ~ht_r & (peakHold_r | peakRise);
    end
  end
  wire logic peakEdge = peakRise | peakHold_r;
  wire logic pos50 = rxLvl_r[1];
  wire logic neg50 = rxLvl_r[2];

  // Registers.
  ppl_ctrl_t ctrl_r;
  ppl_bdata_t txB_r, rxB_r;
  logic [3:0] txD_r, rxD_r;
  logic [31:0] rdata_r;
  logic wait_r;
  logic rxSync_r, rxService_r, rxT_r;
  logic [1:0] rxSfPos_r;
  logic [7:0] rxFrames_r;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  wire logic busReq = avs_read | avs_write;
  wire logic busDone = busReq & ~wait_r;
  wire logic wrCtrl = busDone & avs_write & (avs_address == REG_CTRL);
  wire logic wrTxB = busDone & avs_write & (avs_address == REG_TXB);
  wire logic wrTxD = busDone & avs_write & (avs_address == REG_TXD);
  wire logic [31:0] statWord = {8'h0, rxFrames_r, 6'h0, lineDirTx, rxT_r, rxService_r, rxSync_r, rxSfPos_r, rxD_r};
  wire logic [31:0] readMux =
    (avs_address == REG_CTRL) ? {20'h0, ctrl_r} :
    (avs_address == REG_TXB) ? txB_r :
    (avs_address == REG_TXD) ? {28'h0, txD_r} :
    (avs_address == REG_RXB) ? rxB_r :
    (avs_address == REG_STAT) ? statWord : 32'h0;
  wire logic [31:0] ctrlMerged = mergeBytes({20'h0, ctrl_r}, avs_writedata, avs_byteenable);
  wire logic [31:0] txBMerged = mergeBytes(txB_r, avs_writedata, avs_byteenable);

  // Every access takes one wait cycle: waitrequest drops in the cycle after the request appears.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r <= ~(busReq & wait_r);
      if (busReq & wait_r) begin
        rdata_r <= readMux;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RESET;
      txB_r <= 32'h0;
      txD_r <= 4'h0;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= ctrlMerged[11:0];
      end
      if (wrTxB) begin
        txB_r <= txBMerged;
      end
      if (wrTxD && avs_byteenable[0]) begin
        txD_r <= avs_writedata[3:0];
      end
    end
  end
  wire logic [2:0] oversample_window = avs_writedata[2:0];

  // Burst period sequencer.
  ppl_state_t st_r;
  logic [12:0] perCnt_r;
  wire logic perEnd = perCnt_r == PERIOD_HT - 13'd1;
  // Reception closes a guard time before the period ends, so a late reply never meets our next burst.
  wire logic listenClose = perCnt_r == PERIOD_HT - GUARD_HT - 13'd1;

  // Transmitter state.
  logic [6:0] txPh_r;
  logic [5:0] txIdx_r;
  logic [1:0] txSfPos_r;
  logic lastPol_r, txMark_r, txPolCur_r, dcThis_r;
  wire logic txMbit = (txSfPos_r == 2'd0) ? 1'b1 : (txSfPos_r == 2'd2) ? ctrl_r.txService : ctrl_r.txT;
  // Bits leave from the top of this word; the balance bit follows as an ordinary one.
  wire logic [37:0] txFrame = {1'b1, txB_r.b1[15:8], txB_r.b2[15:8], txD_r[3:2],
    txB_r.b1[7:0], txB_r.b2[7:0], txD_r[1:0], txMbit};
  wire logic txCv = (txIdx_r == FRAME_BITS - 6'd1) & (txSfPos_r == 2'd0);
  wire logic [5:0] txLen = dcThis_r ? FRAME_BITS + 6'd1 : FRAME_BITS;
  wire logic txBitVal = (txIdx_r < FRAME_BITS) ? txFrame[6'd37 - txIdx_r] : 1'b1;
  wire logic txPolNext = txCv ? lastPol_r : ~lastPol_r;
  wire logic txLastBit = (txPh_r == BIT_HT - 7'd1) & (txIdx_r == txLen - 6'd1);
  wire logic dcWanted = ctrl_r.balanceEn & (ctrl_r.activated | ctrl_r.degraded) & (txSfPos_r == 2'd0);
  wire logic pulseOn = (st_r == ST_TX) & txMark_r & (txPh_r > 7'd0) & (txPh_r <= PULSE_HT);

  // Receiver state.
  logic [6:0] rxPh_r;
  logic [5:0] rxIdx_r;
  logic [2:0] smpCnt_r, posCnt_r, trackCnt_r;
  logic trackSign_r, rxLastPol_r;
  logic [37:0] rxShift_r;
  // The window setting is write-only and keeps its last value; a zero setting still asks for one sample.
  logic [2:0] owinStore_r;
  wire logic [2:0] owinN = 3'(owinStore_r * 3'd2);
  wire logic [2:0] needN = (owinN == 3'd0) ? 3'd1 : owinN;
  // Samples sit mid-pulse, so a full phase step either way still leaves all six on the pulse.
  wire logic inSample = (rxPh_r >= SAMPLE_FIRST) & (rxPh_r <= SAMPLE_LAST) & ~rxPh_r[0];
  wire logic [2:0] smpNew = smpCnt_r + 3'((pos50 | neg50) & inSample);
  wire logic [2:0] posNew = posCnt_r + 3'(pos50 & inSample);
  wire logic bitOne = smpCnt_r >= needN;
  wire logic bitPol = posCnt_r >= (smpCnt_r - posCnt_r);
  wire logic rxCvNow = bitOne & (bitPol == rxLastPol_r);
  // A pulse edge in the first half of the cell is late, one in the second half early.
  wire logic errLate = peakEdge & (rxPh_r != 7'd0) & (rxPh_r < PULSE_HT);
  wire logic errEarly = peakEdge & (rxPh_r >= PULSE_HT);
  wire logic errSign = errLate;
  wire logic [2:0] trackNext = (errSign == trackSign_r) ? trackCnt_r + 3'd1 : 3'd1;
  wire logic doAdjust = (errLate | errEarly) & (trackNext == TRACK_COUNT);
  wire logic [1:0] stepHt = ctrl_r.pllStepShort ? STEP_SHORT_HT : STEP_LONG_HT;
  wire logic [7:0] phSum = {1'b0, rxPh_r} + 8'd1 + (doAdjust & errEarly ? {6'h0, stepHt} : 8'h0)
    - (doAdjust & errLate ? {6'h0, stepHt} : 8'h0);
  wire logic phWrap = ~phSum[7] & (phSum >= {1'b0, BIT_HT});
  wire logic phUnder = phSum[7];
  wire logic [37:0] rxFrameNew = {rxShift_r[36:0], bitOne};
  wire logic rxFrameDone = phWrap & (rxIdx_r == FRAME_BITS - 6'd1);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      owinStore_r <= 3'h0;
    end else if (wrCtrl && avs_byteenable[1]) begin
      owinStore_r <= oversample_window;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      perCnt_r <= 13'h0;
    end else if (ht_r) begin
      // A disabled line parks the count at the period end, so enabling launches a burst at the next half-tick.
      if (!ctrl_r.lineEnable) begin
        perCnt_r <= PERIOD_HT - 13'd1;
      end else begin
        perCnt_r <= perEnd ? 13'h0 : perCnt_r + 13'd1;
      end
      unique case (st_r)
        ST_IDLE: if (perEnd && ctrl_r.lineEnable) st_r <= ST_TX;
        ST_TX: if (txLastBit) st_r <= ST_LISTEN;
        ST_LISTEN: begin
          if (listenClose || perEnd) st_r <= ST_IDLE;
          else if (peakEdge) st_r <= ST_RECV;
        end
        ST_RECV: if (listenClose || perEnd || rxFrameDone) st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      txPh_r <= 7'h0;
      txIdx_r <= 6'h0;
      txSfPos_r <= 2'h0;
      lastPol_r <= 1'b0;
      txMark_r <= 1'b0;
      txPolCur_r <= 1'b0;
      dcThis_r <= 1'b0;
    end else if (ht_r) begin
      if (st_r != ST_TX) begin
        txPh_r <= 7'h0;
        txIdx_r <= 6'h0;
        txMark_r <= 1'b0;
        dcThis_r <= dcWanted;
      end else begin
        txPh_r <= (txPh_r == BIT_HT - 7'd1) ? 7'h0 : txPh_r + 7'd1;
        if (txPh_r == BIT_HT - 7'd1) txIdx_r <= txIdx_r + 6'd1;
        if (txPh_r == 7'h0) begin
          txMark_r <= txBitVal;
          if (txBitVal) begin
            txPolCur_r <= txPolNext;
            lastPol_r <= txPolNext;
          end
        end
        if (txLastBit) txSfPos_r <= txSfPos_r + 2'd1;
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      txPos <= 1'b0;
      txNeg <= 1'b0;
      lineDirTx <= 1'b0;
      eqFilterEnable <= 1'b0;
      ampControlSelect <= 2'h0;
    end else begin
      // The pulse covers only the first half of the bit cell.
      txPos <= pulseOn & txPolCur_r;
      txNeg <= pulseOn & ~txPolCur_r;
      lineDirTx <= st_r == ST_TX;
      eqFilterEnable <= ctrl_r.eqFilter;
      ampControlSelect <= ctrl_r.ampControl;
    end
  end

  // Receive timing loop and majority decision.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rxPh_r <= 7'h0;
      rxIdx_r <= 6'h0;
      smpCnt_r <= 3'h0;
      posCnt_r <= 3'h0;
      trackCnt_r <= 3'h0;
      trackSign_r <= 1'b0;
      rxLastPol_r <= 1'b0;
      rxShift_r <= 38'h0;
    end else if (ht_r) begin
      if (st_r != ST_RECV) begin
        rxPh_r <= 7'd1;
        rxIdx_r <= 6'h0;
        smpCnt_r <= 3'h0;
        posCnt_r <= 3'h0;
        if (!ctrl_r.pllIntegral) trackCnt_r <= 3'h0;
      end else begin
        rxPh_r <= phWrap ? 7'(phSum - {1'b0, BIT_HT}) : phUnder ? 7'(phSum + {1'b0, BIT_HT}) : phSum[6:0];
        if (errLate | errEarly) begin
          trackSign_r <= errSign;
          trackCnt_r <= doAdjust ? 3'h0 : trackNext;
        end
        smpCnt_r <= phWrap ? 3'h0 : smpNew;
        posCnt_r <= phWrap ? 3'h0 : posNew;
        if (phWrap) begin
          rxIdx_r <= rxIdx_r + 6'd1;
          rxShift_r <= rxFrameNew;
          if (bitOne) rxLastPol_r <= bitPol;
        end
      end
    end
  end

  // Frame unpacking and superframe tracking.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rxB_r <= 32'h0;
      rxD_r <= 4'h0;
      rxSfPos_r <= 2'h0;
      rxSync_r <= 1'b0;
      rxService_r <= 1'b0;
      rxT_r <= 1'b0;
      rxFrames_r <= 8'h0;
    end else if (ht_r && st_r == ST_RECV && rxFrameDone) begin
      rxB_r.b1 <= {rxFrameNew[36:29], rxFrameNew[18:11]};
      rxB_r.b2 <= {rxFrameNew[28:21], rxFrameNew[10:3]};
      rxD_r <= {rxFrameNew[20:19], rxFrameNew[2:1]};
      rxFrames_r <= rxFrames_r + 8'd1;
      // The count names the place of the frame to come, so a violation frame leaves it at one.
      if (rxCvNow) begin
        rxSfPos_r <= 2'd1;
        rxSync_r <= 1'b1;
      end else begin
        rxSfPos_r <= rxSfPos_r + 2'd1;
        if (rxSfPos_r == 2'd0) rxSync_r <= 1'b0;
        if (rxSfPos_r == 2'd2) rxService_r <= bitOne;
        if (rxSfPos_r[0]) rxT_r <= bitOne;
      end
    end
  end

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;

endmodule : ppl_line_transceiver

// [bench/ppl_line_transceiver_asserts.sv]
// Port checker for the line transceiver: bus handshake, line code and burst timing.
`timescale 1ns/1ns
module ppl_line_transceiver_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Line side
  input wire logic txPos,
  input wire logic txNeg,
  input wire logic lineDirTx
);
  logic [8:0] pulCnt_r;
  logic [15:0] dirCnt_r;
  logic [15:0] perCnt_r;
  logic perSeen_r;
  logic burstGo;
  default clocking dc @(posedge mclk); endclocking
  default disable iff (sys_rst);
  assign burstGo = lineDirTx && dirCnt_r == 16'h0;
  // The period counter may wrap before the first burst, so the first start is not judged.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pulCnt_r <= 9'h0;
      dirCnt_r <= 16'h0;
      perCnt_r <= 16'h0;
      perSeen_r <= 1'b0;
    end else begin
      pulCnt_r <= (txPos || txNeg) ? pulCnt_r + 9'h1 : 9'h0;
      dirCnt_r <= lineDirTx ? dirCnt_r + 16'h1 : 16'h0;
      perCnt_r <= burstGo ? 16'h1 : perCnt_r + 16'h1;
      perSeen_r <= perSeen_r || burstGo;
    end
  end
  bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus request not answered after one wait cycle.");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("Waitrequest low for more than one cycle.");
  wait_rest_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("Waitrequest low without a request.");
  pol_excl_a: assert property (!(txPos && txNeg))
    else $error("Both line polarities driven together.");
  pulse_dir_a: assert property ((txPos || txNeg) |-> lineDirTx)
    else $error("Line pulse outside a transmit burst.");
  pulse_width_a: assert property ($fell(txPos || txNeg) |-> pulCnt_r inside {[323:328]})
    else $error("Line pulse is not half a bit cell.");
  burst_len_a: assert property ($fell(lineDirTx) |-> dirCnt_r inside {[24735:24745], [25386:25396]})
    else $error("Burst length is neither 38 nor 39 bit cells.");
  burst_period_a: assert property ($rose(lineDirTx) && perSeen_r |-> perCnt_r inside {[62497:62503]})
    else $error("Burst start period is not 250 us.");
  lead_one_a: assert property ($rose(lineDirTx) |-> ##[1:16] (txPos || txNeg))
    else $error("Burst does not open with a one.");
endmodule : ppl_line_transceiver_asserts

bind ppl_line_transceiver ppl_line_transceiver_asserts u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .txPos(txPos), .txNeg(txNeg), .lineDirTx(lineDirTx));

// [bench/ppl_terminal_model.sv]
// Behavioural terminal that answers each exchange burst with one AMI coded frame.
`timescale 1ns/1ns
module ppl_terminal_model #(
  parameter logic [15:0] B1 = 16'hc3a5,
  parameter logic [15:0] B2 = 16'h5a3c,
  parameter logic [3:0] D = 4'h6,
  parameter int GAP = 1400
) (
  // Clock
  input wire logic mclk,
  // Exchange side
  input wire logic lineDirTx,
  // Comparator outputs toward the exchange
  output logic rxPeak80,
  output logic rxPos50,
  output logic rxNeg50
);
  logic [37:0] frm;
  logic pol;
  int i;
  // The M bit is sent as a violation, so each frame stands at the first superframe place.
  assign frm = {1'b1, B1[15:8], B2[15:8], D[3:2], B1[7:0], B2[7:0], D[1:0], 1'b1};
  initial begin
    rxPeak80 = 1'b0;
    rxPos50 = 1'b0;
    rxNeg50 = 1'b0;
    pol = 1'b0;
    @(posedge lineDirTx);
    forever begin
      @(negedge lineDirTx);
      repeat (GAP) @(posedge mclk);
      for (i = 37; i >= 0; i--) begin
        if (frm[i]) begin
          pol = (i == 0) ? pol : !pol;
          rxPos50 <= pol;
          rxNeg50 <= !pol;
          rxPeak80 <= 1'b1;
        end
        repeat (325) @(posedge mclk);
        rxPos50 <= 1'b0;
        rxNeg50 <= 1'b0;
        rxPeak80 <= 1'b0;
        repeat (326) @(posedge mclk);
      end
      @(posedge lineDirTx);
    end
  end
endmodule : ppl_terminal_model

// [bench/ppl_tb.sv]
// Self-checking testbench for the ping-pong line transceiver.
`timescale 1ns/1ns
module testbench;
  import ppl_pkg::*;
  localparam logic [15:0] RB1 = 16'hc3a5;
  localparam logic [15:0] RB2 = 16'h5a3c;
  localparam logic [3:0] RD = 4'h6;
  localparam logic [36:0] XF = {1'b1, 8'h80, 8'h12, 2'b10, 8'h01, 8'h34, 2'b11};
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rdVal;
  logic avs_waitrequest, rxPeak80, rxPos50, rxNeg50, txPos, txNeg, lineDirTx, eqFilterEnable;
  logic [1:0] ampControlSelect;
  logic [38:0] lnBits, lnPol;
  logic dirQ = 1'b0;
  logic pulQ = 1'b0;
  int cyc, badCount, nTests;
  always #2 mclk = ~mclk;
  ppl_line_transceiver dut (.mclk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .rxPeak80, .rxPos50, .rxNeg50, .txPos, .txNeg,
    .lineDirTx, .eqFilterEnable, .ampControlSelect);
  ppl_terminal_model #(.B1(RB1), .B2(RB2), .D(RD)) term (.mclk, .lineDirTx, .rxPeak80, .rxPos50, .rxNeg50);
  // Each pulse start is filed under its bit cell, the leading bit in the top place.
  always @(posedge mclk) begin
    if (lineDirTx && !dirQ) begin
      cyc = 0;
      lnBits = '0;
      lnPol = '0;
    end
    if ((txPos || txNeg) && !pulQ && cyc < 25389) begin
      lnBits[38 - cyc / 651] = 1'b1;
      lnPol[38 - cyc / 651] = txPos;
    end
    cyc++;
    dirQ = lineDirTx;
    pulQ = txPos || txNeg;
  end
  task automatic chk(input logic ok, input string msg);
    nTests++;
    if (ok !== 1'b1) begin
      badCount++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic busCycle(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    rdVal = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : busCycle
  task automatic waitBurst;
    while (lineDirTx !== 1'b1) @(posedge mclk);
    while (lineDirTx !== 1'b0) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask : waitBurst
  // A violation is expected only at the M place, bit 1 of the record.
  task automatic chkBurst(input logic [38:0] expB, input logic mViol);
    int i, prev, errs;
    prev = -1;
    errs = 0;
    for (i = 38; i >= 0; i--) begin
      if (lnBits[i] === 1'b1) begin
        if (prev >= 0 && ((lnPol[i] === lnPol[prev]) != (mViol && i == 1))) errs++;
        prev = i;
      end
    end
    chk(lnBits === expB, "burst bits differ");
    chk(errs == 0, "burst polarity differs");
  endtask : chkBurst
  task automatic endSim;
    $display("Comparisons %0d, mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : endSim
  initial begin
    repeat (95000) @(posedge mclk);
    badCount++;
    $display("[FAIL] %0t watchdog expired", $time);
    endSim();
  end
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    chk(avs_waitrequest === 1'b1 && lineDirTx === 1'b0, "reset outputs");
    busCycle(1'b0, REG_CTRL, 32'h0, 4'hf);
    chk(rdVal === 32'(CTRL_RESET), "control reset value");
    busCycle(1'b1, REG_CTRL, 32'h0000_ff80, 4'h1);
    busCycle(1'b1, REG_CTRL, 32'h0000_0603, 4'h2);
    busCycle(1'b0, REG_CTRL, 32'h0, 4'hf);
    chk(rdVal === 32'h0000_0680, "control lanes");
    chk(ampControlSelect === 2'b10 && eqFilterEnable === 1'b0, "equalizer copies");
    busCycle(1'b1, 5'h14, 32'hffff_ffff, 4'hf);
    busCycle(1'b0, 5'h14, 32'h0, 4'hf);
    chk(rdVal === 32'h0, "unmapped read");
    busCycle(1'b1, REG_TXB, 32'h1234_8001, 4'hf);
    busCycle(1'b1, REG_TXD, 32'h0000_000b, 4'h1);
    busCycle(1'b1, REG_CTRL, 32'h0000_0036, 4'h1);
    busCycle(1'b0, REG_CTRL, 32'h0, 4'hf);
    chk(rdVal === 32'h0000_0636, "control enable");
    chk(ampControlSelect === 2'b00 && eqFilterEnable === 1'b1, "equalizer on");
    waitBurst();
    chkBurst({XF, 2'b11}, 1'b1);
    repeat (27000) @(posedge mclk);
    busCycle(1'b0, REG_RXB, 32'h0, 4'hf);
    chk(rdVal === {RB2, RB1}, "received B data");
    busCycle(1'b0, REG_STAT, 32'h0, 4'hf);
    chk((rdVal & 32'h00ff_027f) === {24'h000100, 4'h5, RD}, "receive status");
    waitBurst();
    chkBurst({XF, 2'b10}, 1'b0);
    endSim();
  end
endmodule : testbench
